// File: csim_mode_ctl.sv
// CAN sleep/initialization mode-request control with APB registers.
// Assumes the protocol engine shares pclk; rx_line is an async pin.
// Function
// - Sleep only once receive idle, buffers empty.
// - Set sleep_ack when sleep entered.
// - Ignore sleep_request set while wakeup_flag set.
// - Sleep holds; bus activity may clear request.
// - sleep_request 0 runs, 1 requests sleep.
// - init_request enters init, aborts frames, desyncs.
// - Set init_ack when init entered.
// - Init entry resets listed control registers.
// - Config registers writable only in init.
// - Error counters untouched by init mode.
// - After init, sync on 11 recessive bits.
// - Init exited only when request, ack zero.
// - Force tx_line recessive once init requested.
// - sleep_request clear blocked until sleep entered.
// - init_request clear blocked until init entered.
// - sleep_ack clears with request or wakeup.
`timescale 1ns/100ps
`default_nettype none
module csim_mode_ctl
  import csim_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [CSIM_AW-1:0]   paddr,
  input  wire logic [CSIM_DW-1:0]   pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [CSIM_DW-1:0]   prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire csim_pkg::csim_core_t core,
  output csim_pkg::csim_ctl_t       ctl,
  input  wire logic                 rx_line,
  output logic                      tx_line,
  output logic                      irq
);
  import csim_pkg::*;

  csim_state_t state_q;
  csim_state_t state_d;
  logic [7:0]  ctrl_q;
  logic [7:0]  ctrl_d;
  logic        init_ack_q;
  logic        init_ack_d;
  logic        slp_ack_q;
  logic        slp_ack_d;
  logic        sync_q;
  logic        sync_d;
  logic        tx_q;
  logic        tx_d;
  logic [N_IRQ-1:0] irq_st_q;
  logic [N_IRQ-1:0] irq_st_d;
  logic [N_IRQ-1:0] irq_en_q;
  logic [N_IRQ-1:0] irq_en_d;
  logic [N_IRQ-1:0] ev;
  logic [7:0]  rst_q  [N_RST];
  logic [7:0]  rst_d  [N_RST];
  logic [7:0]  lock_q [N_LOCK];
  logic [7:0]  lock_d [N_LOCK];
  logic [CSIM_DW-1:0] rdata_q;
  logic [CSIM_DW-1:0] rdata_d;
  logic        rx_lvl;
  logic        idle_seen;
  logic        wr;
  logic        setup;
  logic        hit;
  logic        rst_hit;
  logic        lock_hit;
  logic [5:0]  idx;
  logic [2:0]  rst_sel;
  logic [4:0]  lock_sel;
  logic        cfg_open;
  logic        entering_init;

  csim_sync u_rx_sync (
    .pclk      (pclk),
    .presetn   (presetn),
    .pin_in    (rx_line),
    .level_out (rx_lvl)
  );

  // Counter restarts while in init so resync begins at exit
  csim_idle_cnt u_idle (
    .pclk      (pclk),
    .presetn   (presetn),
    .restart   (state_q == ST_INIT),
    .bit_tick  (core.bit_tick),
    .rx_bit    (rx_lvl),
    .idle_seen (idle_seen)
  );

  // Index into a run of registers, or all ones when outside it
  function automatic logic [5:0] run_off(input logic [5:0] i,
                                          input logic [5:0] base,
                                          input logic [5:0] n);
    logic [5:0] d;
    d = i - base;
    run_off = (i >= base && d < n) ? d : 6'h3F;
  endfunction

  // Zero-extend an 8-bit register to the bus width
  function automatic logic [CSIM_DW-1:0] ext8(input logic [7:0] v);
    ext8 = {24'h000000, v};
  endfunction

  // Address decode
  always_comb begin
    logic [5:0] r;
    logic [5:0] c;
    logic [5:0] m;
    r = 6'h3F;
    c = 6'h3F;
    m = 6'h3F;
    idx = paddr[7:2];
    r = run_off(idx, IDX_RST0, 6'(N_RST));
    c = run_off(idx, IDX_CODE0, 6'(N_ACC));
    m = run_off(idx, IDX_MASK0, 6'(N_ACC));
    rst_hit = (r != 6'h3F);
    rst_sel = r[2:0];
    lock_hit = 1'b1;
    lock_sel = 5'h00;
    if (idx == IDX_CFG || idx == IDX_BTR0 || idx == IDX_BTR1 ||
        idx == IDX_ACCCTL) begin
      lock_sel = 5'(idx - IDX_CFG);
    end else if (c != 6'h3F) begin
      lock_sel = 5'(c + 6'(LK_CODE0));
    end else if (m != 6'h3F) begin
      lock_sel = 5'(m + 6'(LK_MASK0));
    end else begin
      lock_hit = 1'b0;
    end
    hit = (paddr[CSIM_AW-1:8] == '0) && (paddr[1:0] == 2'h0) &&
          (idx <= IDX_IRQCLR || rst_hit || lock_hit);
  end

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && pstrb[0] && hit;
  assign cfg_open = ctrl_q[CTRL_INIT] && init_ack_q;

  // Mode request handshake
  always_comb begin
    state_d = state_q;
    ctrl_d = ctrl_q;
    init_ack_d = init_ack_q;
    slp_ack_d = slp_ack_q;
    sync_d = sync_q;
    ev = '0;
    entering_init = 1'b0;
    if (wr && idx == IDX_CTRL) begin
      ctrl_d[7:3] = pwdata[7:3];
      ctrl_d[CTRL_WAKEUP_ENABLE] = pwdata[CTRL_WAKEUP_ENABLE];
      // Set ignored while a wakeup is pending
      if (pwdata[CTRL_SLEEP] && !irq_st_q[IRQ_WAKE]) begin
        ctrl_d[CTRL_SLEEP] = 1'b1;
      end else if (!pwdata[CTRL_SLEEP] && slp_ack_q) begin
        ctrl_d[CTRL_SLEEP] = 1'b0;
      end
      if (pwdata[CTRL_INIT]) begin
        ctrl_d[CTRL_INIT] = 1'b1;
      end else if (init_ack_q) begin
        ctrl_d[CTRL_INIT] = 1'b0;
      end
    end
    unique case (state_q)
      ST_RUN: begin
        if (ctrl_q[CTRL_INIT]) begin
          state_d = ST_INIT;
          entering_init = 1'b1;
        end else if (ctrl_q[CTRL_SLEEP] && !core.rx_busy &&
                     !core.tx_pending) begin
          state_d = ST_SLEEP;
          slp_ack_d = 1'b1;
          ev[IRQ_SLEEP] = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (ctrl_q[CTRL_INIT]) begin
          state_d = ST_INIT;
          slp_ack_d = 1'b0;
          entering_init = 1'b1;
        end else if (!ctrl_q[CTRL_SLEEP]) begin
          state_d = ST_RUN;
          slp_ack_d = 1'b0;
        end else if (ctrl_q[CTRL_WAKEUP_ENABLE] && !rx_lvl) begin
          // Dominant level on the bus counts as activity
          state_d = ST_RUN;
          slp_ack_d = 1'b0;
          ctrl_d[CTRL_SLEEP] = 1'b0;
          ev[IRQ_WAKE] = 1'b1;
        end
      end
      ST_INIT: begin
        if (!ctrl_q[CTRL_INIT]) begin
          state_d = ST_RUN;
          init_ack_d = 1'b0;
        end
      end
    endcase
    if (entering_init) begin
      init_ack_d = 1'b1;
      ev[IRQ_INIT] = 1'b1;
      ctrl_d = (ctrl_d & CTRL_KEEP) | (CTRL_RST & ~CTRL_KEEP);
    end
    if (entering_init || state_q == ST_INIT) begin
      sync_d = 1'b0;
    end else if (idle_seen && !core.bus_off && !sync_q) begin
      sync_d = 1'b1;
      ev[IRQ_SYNC] = 1'b1;
    end
    // Recessive from the request on, before the ack arrives
    tx_d = (ctrl_d[CTRL_INIT] || state_d != ST_RUN || !sync_d) ?
           1'b1 : core.tx_bit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_RUN;
      ctrl_q <= CTRL_RST;
      init_ack_q <= 1'b0;
      slp_ack_q <= 1'b0;
      sync_q <= 1'b0;
      tx_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      init_ack_q <= init_ack_d;
      slp_ack_q <= slp_ack_d;
      sync_q <= sync_d;
      tx_q <= tx_d;
    end
  end

  // Register storage and interrupts
  always_comb begin
    irq_en_d = irq_en_q;
    irq_st_d = irq_st_q;
    for (int i = 0; i < N_RST; i++) begin
      rst_d[i] = rst_q[i];
    end
    for (int i = 0; i < N_LOCK; i++) begin
      lock_d[i] = lock_q[i];
    end
    if (wr && idx == IDX_IRQEN) begin
      irq_en_d = pwdata[N_IRQ-1:0];
    end
    if (wr && idx == IDX_IRQCLR) begin
      irq_st_d = irq_st_q & ~pwdata[N_IRQ-1:0];
    end
    // A new event wins over a clear in the same cycle
    irq_st_d = irq_st_d | ev;
    if (wr && rst_hit) begin
      rst_d[rst_sel] = pwdata[7:0];
    end
    if (wr && lock_hit && cfg_open) begin
      lock_d[lock_sel] = pwdata[7:0];
    end
    if (entering_init) begin
      for (int i = 0; i < N_RST; i++) begin
        rst_d[i] = REG_RST;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= '0;
      irq_st_q <= '0;
      for (int i = 0; i < N_RST; i++) begin
        rst_q[i] <= REG_RST;
      end
      for (int i = 0; i < N_LOCK; i++) begin
        lock_q[i] <= REG_RST;
      end
    end else begin
      irq_en_q <= irq_en_d;
      irq_st_q <= irq_st_d;
      rst_q <= rst_d;
      lock_q <= lock_d;
    end
  end

  // Read data is captured in the setup phase so prdata is registered
  always_comb begin
    rdata_d = rdata_q;
    if (setup) begin
      rdata_d = '0;
      if (rst_hit) begin
        rdata_d = ext8(rst_q[rst_sel]);
      end else if (lock_hit) begin
        rdata_d = ext8(lock_q[lock_sel]);
      end else begin
        unique case (idx)
          IDX_CTRL: rdata_d = ext8(ctrl_q);
          IDX_STAT: rdata_d = ext8({4'h0, core.bus_off, sync_q,
                                    slp_ack_q, init_ack_q});
          // Counters come straight from the engine, mode never touches them
          IDX_ERRCNT: rdata_d = {16'h0000, core.rx_err_cnt,
                                 core.tx_err_cnt};
          IDX_IRQSTAT: rdata_d = ext8({4'h0, irq_st_q});
          IDX_IRQEN: rdata_d = ext8({4'h0, irq_en_q});
          default: rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign tx_line = tx_q;
  assign irq = |(irq_st_q & irq_en_q);
  assign ctl.abort = (state_q == ST_INIT) || ctrl_q[CTRL_INIT];
  assign ctl.synced = sync_q;
  assign ctl.sleeping = slp_ack_q;
  assign ctl.init_mode = init_ack_q;
endmodule
`default_nettype wire

// File: csim_pkg.sv
// Shared constants and types for the CAN mode-request control block.
// Assumes a single pclk domain and a 32-bit APB register bus.
package csim_pkg;

  localparam int unsigned CSIM_AW = 12;
  localparam int unsigned CSIM_DW = 32;

  // Register word indices; byte address is four times the index
  localparam logic [5:0] IDX_CTRL    = 6'h00;
  localparam logic [5:0] IDX_STAT    = 6'h01;
  localparam logic [5:0] IDX_CFG     = 6'h02;
  localparam logic [5:0] IDX_BTR0    = 6'h03;
  localparam logic [5:0] IDX_BTR1    = 6'h04;
  localparam logic [5:0] IDX_ACCCTL  = 6'h05;
  localparam logic [5:0] IDX_ERRCNT  = 6'h06;
  localparam logic [5:0] IDX_IRQSTAT = 6'h07;
  localparam logic [5:0] IDX_IRQEN   = 6'h08;
  localparam logic [5:0] IDX_IRQCLR  = 6'h09;
  // Seven registers cleared on init entry, receive flags first
  localparam logic [5:0] IDX_RST0    = 6'h0A;
  localparam int unsigned N_RST      = 7;
  // Acceptance code then acceptance mask, eight each
  localparam logic [5:0] IDX_CODE0   = 6'h20;
  localparam logic [5:0] IDX_MASK0   = 6'h28;
  localparam int unsigned N_ACC      = 8;
  // Locked array: cfg, btr0, btr1, accctl, codes, masks
  localparam int unsigned N_LOCK     = 20;
  localparam int unsigned LK_CODE0   = 4;
  localparam int unsigned LK_MASK0   = 12;

  // mode_control_reg fields
  localparam int unsigned CTRL_INIT  = 0;
  localparam int unsigned CTRL_SLEEP = 1;
  localparam int unsigned CTRL_WAKEUP_ENABLE  = 2;
  // Status fields
  localparam int unsigned STAT_INITACK = 0;
  localparam int unsigned STAT_SLPACK  = 1;
  localparam int unsigned STAT_SYNC    = 2;
  localparam int unsigned STAT_BUSOFF  = 3;
  // Interrupt status bits
  localparam int unsigned IRQ_INIT  = 0;
  localparam int unsigned IRQ_SLEEP = 1;
  localparam int unsigned IRQ_WAKE  = 2;
  localparam int unsigned IRQ_SYNC  = 3;
  localparam int unsigned N_IRQ     = 4;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] REG_RST  = 8'h00;
  // Bits kept across init entry: sleep, init and wakeup enable
  localparam logic [7:0] CTRL_KEEP = 8'h07;

  // Consecutive recessive bits needed to resynchronise
  localparam logic [3:0] SYNC_BITS = 4'hB;

  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_INIT} csim_state_t;

  // Status from the protocol engine, same clock domain
  typedef struct packed {
    logic       rx_busy;
    logic       tx_pending;
    logic       bus_off;
    logic       bit_tick;
    logic       tx_bit;
    logic [7:0] tx_err_cnt;
    logic [7:0] rx_err_cnt;
  } csim_core_t;

  // Control toward the protocol engine
  typedef struct packed {
    logic abort;
    logic synced;
    logic sleeping;
    logic init_mode;
  } csim_ctl_t;

endpackage

// File: csim_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input level; idles at the recessive level.
`timescale 1ns/100ps
`default_nettype none
module csim_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level_out
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;
  logic       lvl_q;
  logic       lvl_d;

  always_comb begin
    sh_d = {sh_q[1:0], pin_in};
    lvl_d = lvl_q;
    // Only later stages are compared; the first stage may be metastable
    if (sh_q[1] == sh_q[2]) begin
      lvl_d = sh_q[2];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= 3'h7;
      lvl_q <= 1'b1;
    end else begin
      sh_q <= sh_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_out = lvl_q;
endmodule
`default_nettype wire

// File: csim_idle_cnt.sv
// Counts consecutive recessive bits at each sample tick.
// Assumes bit_tick is a one-cycle strobe from the bit timing logic.
`timescale 1ns/100ps
`default_nettype none
module csim_idle_cnt
  import csim_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic restart,
  input  wire logic bit_tick,
  input  wire logic rx_bit,
  output logic      idle_seen
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q;
    if (restart) begin
      cnt_d = 4'h0;
    end else if (bit_tick) begin
      if (!rx_bit) begin
        cnt_d = 4'h0;
      end else if (cnt_q != SYNC_BITS) begin
        cnt_d = cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign idle_seen = (cnt_q == SYNC_BITS);
endmodule
`default_nettype wire

// File: csim_mode_ctl_assertions.sv
// Port-level checker for the CAN mode-request block.
// Assumes one pclk domain; bound to every csim_mode_ctl instance.
`timescale 1ns/100ps
`default_nettype none
module csim_mode_ctl_assertions
  import csim_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [CSIM_AW-1:0]   paddr,
  input  wire logic [CSIM_DW-1:0]   pwdata,
  input  wire logic [3:0]           pstrb,
  input  wire logic [CSIM_DW-1:0]   prdata,
  input  wire logic                 pready,
  input  wire logic                 pslverr,
  input  wire csim_pkg::csim_core_t core,
  input  wire csim_pkg::csim_ctl_t  ctl,
  input  wire logic                 rx_line,
  input  wire logic                 tx_line,
  input  wire logic                 irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       wr_ctl;
  logic [3:0] tk_q;
  logic [3:0] tk_d;
  assign wr_ctl = psel && penable && pwrite && paddr == 12'h000 && pstrb[0];
  // Ticks since init exit; the design cannot have counted more
  always_comb begin
    tk_d = tk_q;
    if (ctl.init_mode) tk_d = 4'h0;
    else if (core.bit_tick && tk_q != 4'hF) tk_d = tk_q + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tk_q <= 4'h0;
    else tk_q <= tk_d;
  end
  sequence s_init_req;
    wr_ctl && pwdata[0];
  endsequence
  sequence s_sleep_drop;
    wr_ctl && !pwdata[1] && ctl.sleeping;
  endsequence
  // Request bit lands at the write edge, the ack one edge later
  a_init_ack_next: assert property (s_init_req |=> ##1 ctl.init_mode)
    else $error("init ack missing");
  a_tx_recessive: assert property (ctl.abort |-> tx_line)
    else $error("tx not recessive in init");
  a_sleep_when_idle: assert property ($rose(ctl.sleeping) |->
    !$past(core.rx_busy) && !$past(core.tx_pending))
    else $error("sleep entered on busy bus");
  a_init_exit_req: assert property ($fell(ctl.init_mode) |->
    $past(wr_ctl, 2) && !$past(pwdata[0], 2))
    else $error("init left without request clear");
  a_sleep_ack_drop: assert property (s_sleep_drop |=> ##1 !ctl.sleeping)
    else $error("sleep ack kept");
  a_sync_eleven: assert property ($rose(ctl.synced) |-> tk_q >= 4'hB)
    else $error("synced too early");
  a_init_desync: assert property (ctl.init_mode |-> !ctl.synced)
    else $error("synced in init");
  a_err_cnt_keep: assert property (psel && !penable && paddr == 12'h018 |=>
    prdata[15:0] == {$past(core.rx_err_cnt), $past(core.tx_err_cnt)})
    else $error("error counters altered");
  a_unmapped_err: assert property (psel && penable && paddr == 12'h044 |->
    pslverr && pready)
    else $error("unmapped access not refused");
endmodule
bind csim_mode_ctl csim_mode_ctl_assertions u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .core(core), .ctl(ctl),
  .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
`default_nettype wire

// File: csim_bus_node.sv
// Other nodes on the CAN bus plus the bit sample strobe.
// Assumes a wired-AND bus where 0 is dominant.
`timescale 1ns/100ps
`default_nettype none
module csim_bus_node (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tx_line,
  input  wire logic dom,
  output logic      rx_line,
  output logic      bit_tick
);
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  // Any node driving dominant wins the bus
  assign rx_line = tx_line & ~dom;
  assign ph_d = ph_q + 2'h1;
  assign bit_tick = (ph_q == 2'h3);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_q <= 2'h0;
    else ph_q <= ph_d;
  end
endmodule
`default_nettype wire

// File: test_can_sleep_init_mode_control.sv
// Testbench: APB tasks drive the mode-request block through its modes.
// Assumes csim_bus_node stands for the bus; error counters held fixed.
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  bad_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module test_can_sleep_init_mode_control;
  import csim_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, lerr;
  logic        rx_busy, tx_pending, bus_off, bit_tick, tx_bit, dom;
  logic        rx_line, tx_line, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  pstrb;
  csim_core_t  core;
  csim_ctl_t   ctl;
  int          bad_count, checks_done, cyc;
  assign core = {rx_busy, tx_pending, bus_off, bit_tick, tx_bit, 8'h34, 8'h12};
  csim_mode_ctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core(core), .ctl(ctl), .rx_line(rx_line), .tx_line(tx_line),
    .irq(irq));
  csim_bus_node u_bus (.pclk(pclk), .presetn(presetn), .tx_line(tx_line),
    .dom(dom), .rx_line(rx_line), .bit_tick(bit_tick));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    lerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-raises psel in this step
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // Retries cover acks landing one edge after the read was set up
  task automatic chk(input logic [11:0] a, input logic [31:0] m, e,
                     input int t);
    int n;
    n = 0;
    xfer(1'b0, a, 32'h0);
    while ((r & m) !== e && n < t) begin
      xfer(1'b0, a, 32'h0);
      n++;
    end
    `CHK(r & m, e)
  endtask
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, rx_busy, tx_pending, bus_off} = 7'h00;
    {tx_bit, dom, paddr, pwdata, pstrb} = {2'b00, 12'h000, 32'h0, 4'hF};
    {bad_count, checks_done, cyc} = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(12'h000, 32'hFF, 32'h00, 0);
    chk(12'h004, 32'h0F, 32'h00, 0);
    chk(12'h044, 32'hFFFFFFFF, 32'h0, 0);
    `CHK(lerr, 1'b1)
    wr(12'h008, 32'h5A);
    chk(12'h008, 32'hFF, 32'h00, 0);
    wr(12'h000, 32'hF8);
    wr(12'h028, 32'hA5);
    chk(12'h028, 32'hFF, 32'hA5, 0);
    // Synchronised with tx_bit low, so the engine's dominant bit shows on tx_line
    chk(12'h004, 32'h04, 32'h04, 40);
    `CHK(tx_line, 1'b0)
    wr(12'h000, 32'hF9);
    chk(12'h004, 32'h01, 32'h01, 2);
    `CHK(ctl, 4'h9)
    `CHK(tx_line, 1'b1)
    chk(12'h000, 32'hFF, 32'h01, 2);
    chk(12'h028, 32'hFF, 32'h00, 0);
    wr(12'h008, 32'h5A);
    chk(12'h008, 32'hFF, 32'h5A, 0);
    wr(12'h080, 32'h3C);
    chk(12'h080, 32'hFF, 32'h3C, 0);
    chk(12'h018, 32'hFFFF, 32'h1234, 0);
    tx_bit <= 1'b1;
    wr(12'h000, 32'h00);
    chk(12'h004, 32'h05, 32'h00, 2);
    chk(12'h004, 32'h04, 32'h04, 40);
    tx_pending <= 1'b1;
    wr(12'h000, 32'h02);
    wr(12'h000, 32'h00);
    chk(12'h000, 32'h02, 32'h02, 0);
    chk(12'h004, 32'h02, 32'h00, 0);
    tx_pending <= 1'b0;
    chk(12'h004, 32'h02, 32'h02, 10);
    `CHK(ctl, 4'h6)
    wr(12'h000, 32'h00);
    chk(12'h004, 32'h02, 32'h00, 2);
    wr(12'h024, 32'h0F);
    wr(12'h020, 32'h04);
    wr(12'h000, 32'h06);
    chk(12'h004, 32'h02, 32'h02, 10);
    `CHK(irq, 1'b0)
    dom <= 1'b1;
    chk(12'h000, 32'h02, 32'h00, 20);
    chk(12'h004, 32'h02, 32'h00, 0);
    chk(12'h01C, 32'h04, 32'h04, 0);
    `CHK(irq, 1'b1)
    dom <= 1'b0;
    wr(12'h000, 32'h02);
    chk(12'h000, 32'h02, 32'h00, 0);
    wr(12'h020, 32'h00);
    chk(12'h01C, 32'h04, 32'h04, 0);
    `CHK(irq, 1'b0)
    wr(12'h020, 32'h04);
    wr(12'h024, 32'h04);
    chk(12'h01C, 32'h04, 32'h00, 0);
    `CHK(irq, 1'b0)
    give_verdict();
  end
endmodule
`default_nettype wire
